/* core/adr_pkg.sv */
/*
 * Constants shared by the acceleration readout register block: register
 * indices, field positions, reset values and bus widths.
 * Assumes a byte-addressed APB bus; byte address is four times the index.
 */
package adr_pkg;
	// Register indices; byte address = index * 4
	localparam logic [5:0] ADR_IDX_ID     = 6'h00;
	localparam logic [5:0] ADR_IDX_X_LOW  = 6'h02;
	localparam logic [5:0] ADR_IDX_X_HIGH = 6'h03;
	localparam logic [5:0] ADR_IDX_Y_LOW  = 6'h04;
	localparam logic [5:0] ADR_IDX_Y_HIGH = 6'h05;
	localparam logic [5:0] ADR_IDX_Z_LOW  = 6'h06;
	localparam logic [5:0] ADR_IDX_Z_HIGH = 6'h07;
	localparam logic [5:0] ADR_IDX_CTRL   = 6'h10;
	localparam logic [5:0] ADR_IDX_STS    = 6'h11;
	localparam logic [5:0] ADR_IDX_MASK   = 6'h12;

	// Low data register fields
	localparam int ADR_LOW_FRESH_BIT = 0;
	localparam int ADR_LOW_SMP_LSB   = 4;

	// Control register fields
	localparam int ADR_CTRL_LOCK_DIS_BIT = 0;
	localparam int ADR_CTRL_SLEEP_BIT    = 1;

	// Interrupt status and mask fields
	localparam int ADR_INT_NEW_BIT = 0;
	localparam int ADR_INT_OVR_BIT = 1;

	// Reset values
	localparam logic [1:0] ADR_CTRL_RST = 2'h0;
	localparam logic [1:0] ADR_INT_RST  = 2'h0;

	// Widths
	localparam int ADR_SMP_W   = 12;
	localparam int ADR_AXES    = 3;
	localparam int ADR_DATA_W  = 32;
	localparam int ADR_ADDR_W  = 8;
endpackage : adr_pkg

/* core/adr_axis.sv */
/*
 * One acceleration axis: sample store, upper-byte lock and fresh flag.
 * Assumes read strobes are one-cycle pulses from the bus slave and that
 * a low read and a high read never arrive in the same cycle.
 */
`timescale 1ns/100ps

module adr_axis
	import adr_pkg::*;
(
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	// Conversion side
	input  wire logic                 i_load,
	input  wire logic [ADR_SMP_W-1:0] i_sample,
	// Register side
	input  wire logic                 i_rd_low,
	input  wire logic                 i_rd_high,
	input  wire logic                 i_lock_dis,
	output logic      [7:0]           o_low,
	output logic      [7:0]           o_high,
	output logic                      o_frozen
);

	typedef struct packed {
		logic [ADR_SMP_W-1:0] smp;
		logic [7:0]           hi;
		logic                 frz;
		logic                 fresh;
	} adr_axis_s;

	adr_axis_s q;
	adr_axis_s d;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		if (i_load) begin
			d.smp = i_sample;
		end
		// [RL6] lock on low read
		if (i_rd_low && !i_lock_dis) begin
			d.frz = 1'b1;
		end
		if (i_rd_high || i_lock_dis) begin
			d.frz = 1'b0;
		end
		// Upper byte tracks the store only while unlocked
		if (!d.frz) begin
			d.hi = d.smp[ADR_SMP_W-1:4];
		end
		// [RL12] clear once the high byte is read
		if (i_rd_high) begin
			d.fresh = 1'b0;
		end
		// [RL5] new sample wins
		if (i_load) begin
			d.fresh = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// [RL2] [RL4] low nibble, zero pad, fresh bit
	assign o_low    = {q.smp[3:0], 3'h0, q.fresh};
	// [RL3] sign in bit 7
	assign o_high   = q.hi;
	assign o_frozen = q.frz;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_low_read;
		i_rd_low && !i_lock_dis;
	endsequence

	sequence s_load_while_locked;
		i_load && !i_rd_high && !i_lock_dis;
	endsequence

	AST_FRESH_SET: assert property ( // RL5
		i_load |=> o_low[ADR_LOW_FRESH_BIT])
		else $error("fresh flag not set by new sample");

	AST_FRESH_CLR: assert property ( // RL12
		i_rd_high && !i_load |=> !o_low[ADR_LOW_FRESH_BIT])
		else $error("fresh flag not cleared by read");

	AST_LOCK_HOLD: assert property ( // RL6
		s_low_read ##1 s_load_while_locked
		|=> o_high == $past(o_high, 2))
		else $error("upper byte changed while locked");

	AST_UNLOCKED_TRACK: assert property ( // RL3
		!o_frozen && !i_rd_low && !i_load
		|=> o_high == $past(q.smp[ADR_SMP_W-1:4]))
		else $error("upper byte does not track sample");
endmodule // adr_axis

/* core/adr_regs.sv */
/*
 * APB slave holding the identity register and the three axis sample pairs,
 * with control, interrupt status and mask registers.
 * Assumes samples arrive on the same clock as a one-cycle valid pulse and
 * the APB master holds each request until pready.
 */
// Chosen here: the APB register port.
// Function
// [RL1] Offset 0x00 reads a fixed identity byte and ignores writes.
// [RL2] Low register bits 7..4 hold sample bits 3..0.
// [RL3] High register holds sample bits 11..4, sign in bit 7.
// [RL4] Low register bits 3..1 are undefined; host masks them.
// [RL5] Low register bit 0 is set when the axis has a new value.
// [RL6] Low read locks the high register until high is read.
// [RL7] Host reads low before high for a consistent sample.
// [RL8] No data reads during power-up or deepest sleep.
// [RL9] X pair sits at offsets 0x02 and 0x03.
// [RL10] Y pair sits at offsets 0x04 and 0x05.
// [RL11] Z pair sits at offsets 0x06 and 0x07.
// [RL12] Fresh flag clears on read, sets again on new sample.
`timescale 1ns/100ps

module adr_regs
	import adr_pkg::*;
#(
	// Arbitrary identity value
	parameter logic [7:0] PART_ID = 8'h5C
) (
	// Clock and reset
	input  wire logic                  I_SYS_CLK,
	input  wire logic                  I_RESET_N,
	// APB slave
	input  wire logic                  I_PSEL,
	input  wire logic                  I_PENABLE,
	input  wire logic                  I_PWRITE,
	input  wire logic [ADR_ADDR_W-1:0] I_PADDR,
	input  wire logic [ADR_DATA_W-1:0] I_PWDATA,
	output logic      [ADR_DATA_W-1:0] O_PRDATA,
	output logic                       O_PREADY,
	output logic                       O_PSLVERR,
	// Conversion results
	input  wire logic                  I_SAMPLE_VALID,
	input  wire logic [ADR_SMP_W-1:0]  I_SAMPLE_X,
	input  wire logic [ADR_SMP_W-1:0]  I_SAMPLE_Y,
	input  wire logic [ADR_SMP_W-1:0]  I_SAMPLE_Z,
	// Interrupt
	output logic                       O_IRQ
);

	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
		logic       err;
		logic [1:0] ctrl;
		logic [1:0] sts;
		logic [1:0] mask;
	} adr_regs_s;

	adr_regs_s q;
	adr_regs_s d;

	logic [5:0]           idx;
	logic                 aligned;
	logic                 cap;
	logic                 done;
	logic                 rd_cap;
	logic                 data_idx;
	logic                 sleeping;
	logic                 lock_dis;
	logic [ADR_AXES-1:0]  rd_low;
	logic [ADR_AXES-1:0]  rd_high;
	logic [ADR_AXES-1:0]  frozen;
	logic [7:0]           ax_low  [ADR_AXES];
	logic [7:0]           ax_high [ADR_AXES];
	logic [ADR_SMP_W-1:0] ax_smp  [ADR_AXES];
	logic [1:0]           events;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign idx      = I_PADDR[7:2];
	assign aligned  = (I_PADDR[1:0] == 2'h0);
	// First access cycle captures; second completes with pready
	assign cap      = I_PSEL && I_PENABLE && !q.ack;
	assign done     = I_PSEL && I_PENABLE && q.ack;
	assign rd_cap   = cap && !I_PWRITE;
	assign sleeping = q.ctrl[ADR_CTRL_SLEEP_BIT];
	assign lock_dis = q.ctrl[ADR_CTRL_LOCK_DIS_BIT];
	assign data_idx = aligned && (idx >= ADR_IDX_X_LOW)
		&& (idx <= ADR_IDX_Z_HIGH);

	assign ax_smp[0] = I_SAMPLE_X;
	assign ax_smp[1] = I_SAMPLE_Y;
	assign ax_smp[2] = I_SAMPLE_Z;

	////////////////////////////////////////////////////////////////////////
	// Axis stores
	genvar g;
	generate
		for (g = 0; g < ADR_AXES; g++) begin : g_axis
			// [RL9] pair at 2 + 2*axis
			localparam logic [5:0] LO =
				ADR_IDX_X_LOW + 6'(2 * g);
			// [RL8] refused reads leave no trace
			assign rd_low[g]  = rd_cap && aligned && !sleeping
				&& (idx == LO);
			assign rd_high[g] = rd_cap && aligned && !sleeping
				&& (idx == LO + 6'h01);

			adr_axis u_axis (
				.i_clk      (I_SYS_CLK),
				.i_rst_n    (I_RESET_N),
				.i_load     (I_SAMPLE_VALID),
				.i_sample   (ax_smp[g]),
				.i_rd_low   (rd_low[g]),
				.i_rd_high  (rd_high[g]),
				.i_lock_dis (lock_dis),
				.o_low      (ax_low[g]),
				.o_high     (ax_high[g]),
				.o_frozen   (frozen[g])
			);
		end
	endgenerate

	// Samples that arrive while an upper byte is held are flagged
	assign events[ADR_INT_NEW_BIT] = I_SAMPLE_VALID;
	assign events[ADR_INT_OVR_BIT] = I_SAMPLE_VALID && (|frozen);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d     = q;
		d.ack = cap;
		if (cap) begin
			d.rdata = 8'h00;
			d.err   = 1'b0;
			if (!aligned) begin
				d.err = 1'b1;
			end else if (data_idx && sleeping) begin
				// [RL8] refuse sample reads
				d.err = 1'b1;
			end else begin
				unique case (idx)
					// [RL1] fixed identity
					ADR_IDX_ID:     d.rdata = PART_ID;
					// [RL9] X pair
					ADR_IDX_X_LOW:  d.rdata = ax_low[0];
					ADR_IDX_X_HIGH: d.rdata = ax_high[0];
					// [RL10] Y pair
					ADR_IDX_Y_LOW:  d.rdata = ax_low[1];
					ADR_IDX_Y_HIGH: d.rdata = ax_high[1];
					// [RL11] Z pair
					ADR_IDX_Z_LOW:  d.rdata = ax_low[2];
					ADR_IDX_Z_HIGH: d.rdata = ax_high[2];
					ADR_IDX_CTRL:   d.rdata = {6'h00, q.ctrl};
					ADR_IDX_STS:    d.rdata = {6'h00, q.sts};
					ADR_IDX_MASK:   d.rdata = {6'h00, q.mask};
					default:        d.err   = 1'b1;
				endcase
			end
		end
		// Writes take effect only at the completing edge
		if (done && I_PWRITE && aligned) begin
			unique case (idx)
				ADR_IDX_CTRL: d.ctrl = I_PWDATA[1:0];
				ADR_IDX_MASK: d.mask = I_PWDATA[1:0];
				ADR_IDX_STS:  d.sts  = q.sts & ~I_PWDATA[1:0];
				default:      d.ctrl = q.ctrl;
			endcase
		end
		// Events set after the clear so a set in the same cycle wins
		d.sts = d.sts | events;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESET_N) begin
			q      <= '0;
			q.ctrl <= ADR_CTRL_RST;
			q.sts  <= ADR_INT_RST;
			q.mask <= ADR_INT_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign O_PREADY  = done;
	// Identity and data are read-only: writes there answer with error
	assign O_PSLVERR = done && (I_PWRITE
		? !(aligned && (idx == ADR_IDX_CTRL || idx == ADR_IDX_STS
			|| idx == ADR_IDX_MASK))
		: q.err);
	assign O_PRDATA  = {24'h000000, q.rdata};
	assign O_IRQ     = |(q.sts & q.mask);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);

	sequence s_rd_done(logic [5:0] r);
		done && !I_PWRITE && aligned && !sleeping && idx == r;
	endsequence

	AST_ID_READ: assert property ( // RL1
		s_rd_done(ADR_IDX_ID) |-> O_PRDATA == {24'h000000, PART_ID})
		else $error("identity read returned wrong value");

	AST_ID_NO_WRITE: assert property ( // RL1
		done && I_PWRITE && aligned && idx == ADR_IDX_ID |-> O_PSLVERR)
		else $error("write to identity not refused");

	AST_X_LOW: assert property ( // RL2 RL9
		s_rd_done(ADR_IDX_X_LOW)
		|-> O_PRDATA[7:ADR_LOW_SMP_LSB] == $past(ax_low[0][7:4]))
		else $error("x low read wrong nibble");

	AST_Y_HIGH: assert property ( // RL3 RL10
		s_rd_done(ADR_IDX_Y_HIGH) |-> O_PRDATA[7:0] == $past(ax_high[1]))
		else $error("y high read wrong byte");

	AST_Z_HIGH: assert property ( // RL11
		s_rd_done(ADR_IDX_Z_HIGH) |-> O_PRDATA[7:0] == $past(ax_high[2]))
		else $error("z high read wrong byte");

	AST_UNDEF_ZERO: assert property ( // RL4
		s_rd_done(ADR_IDX_Y_LOW) |-> O_PRDATA[3:1] == 3'h0)
		else $error("undefined low bits not zero");

	AST_FRESH_READ: assert property ( // RL5
		s_rd_done(ADR_IDX_Z_LOW)
		|-> O_PRDATA[ADR_LOW_FRESH_BIT] == $past(ax_low[2][0]))
		else $error("fresh flag read wrong");

	AST_LOCK_ON_READ: assert property ( // RL6
		rd_low[0] && !lock_dis |=> frozen[0])
		else $error("x upper byte not locked after low read");

	AST_SLEEP_REFUSE: assert property ( // RL8
		done && !I_PWRITE && data_idx && sleeping |-> O_PSLVERR)
		else $error("data read in deep sleep not refused");

	AST_ONE_WAIT: assert property (
		I_PSEL && I_PENABLE && !q.ack |-> !O_PREADY ##1 O_PREADY)
		else $error("access did not complete after one wait");

	AST_IRQ_STICKY: assert property (
		I_SAMPLE_VALID |=> q.sts[ADR_INT_NEW_BIT] [*2]
		or (q.sts[ADR_INT_NEW_BIT] ##1 done))
		else $error("new sample status not sticky");
endmodule // adr_regs

/* sim/adr_host.sv */
/*
 * Host model on the APB side: single transfers and low-then-high pairs.
 * Assumes the slave answers with pready; every wait is bounded.
 */
`timescale 1ns/100ps

module adr_host
	import adr_pkg::*;
(
	// Clock
	input  wire logic                  i_clk,
	// APB master
	output logic                       o_psel,
	output logic                       o_penable,
	output logic                       o_pwrite,
	output logic      [ADR_ADDR_W-1:0] o_paddr,
	output logic      [ADR_DATA_W-1:0] o_pwdata,
	input  wire logic [ADR_DATA_W-1:0] i_prdata,
	input  wire logic                  i_pready,
	input  wire logic                  i_pslverr
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Pready is sampled at the rising edge, before the slave's edge updates
	task automatic xfer(input logic w, input logic [5:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= {idx, 2'b00};
		o_pwdata <= wd;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 40);
		rd = i_prdata;
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask

	task automatic rd_pair(input logic [5:0] lo_idx,
		output logic [31:0] lo, output logic [31:0] hi);
		logic e;
		xfer(1'b0, lo_idx, 32'h0, lo, e);
		xfer(1'b0, lo_idx + 6'h01, 32'h0, hi, e);
	endtask
endmodule // adr_host

/* sim/tb_adr_regs.sv */
/*
 * Self-checking bench for the readout register block.
 * Assumes the host model drives APB and this bench drives the samples.
 */
`timescale 1ns/100ps

module tb_adr_regs
	import adr_pkg::*;
;
	// Arbitrary identity value
	localparam logic [7:0] ID_VAL = 8'h3C;
	logic                  clk, rst_n, psel, penable, pwrite;
	logic                  pready, pslverr, irq, s_valid, err;
	logic [ADR_ADDR_W-1:0] paddr;
	logic [ADR_DATA_W-1:0] pwdata, prdata, rl, rh;
	logic [ADR_SMP_W-1:0]  sx, sy, sz;
	logic [ADR_SMP_W-1:0]  smp [3];
	int                    num_errors = 0;
	int                    comparisons = 0;

	adr_regs #(.PART_ID(ID_VAL)) i_adr_regs (.I_SYS_CLK(clk),
		.I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_SAMPLE_VALID(s_valid), .I_SAMPLE_X(sx), .I_SAMPLE_Y(sy),
		.I_SAMPLE_Z(sz), .O_IRQ(irq));
	adr_host i_adr_host (.i_clk(clk), .o_psel(psel), .o_penable(penable),
		.o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
		.i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic load(input logic [11:0] x, y, z);
		@(posedge clk);
		s_valid <= 1'b1;
		sx <= x;
		sy <= y;
		sz <= z;
		smp = '{x, y, z};
		@(posedge clk);
		s_valid <= 1'b0;
	endtask

	task automatic rw(input logic w, input logic [5:0] i, input logic [31:0] d);
		i_adr_host.xfer(w, i, d, rl, err);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_ident();
		rw(0, ADR_IDX_ID, 0);
		chk("id", rl, {24'h0, ID_VAL});
		rw(1, ADR_IDX_ID, 32'hFF);
		chk("id_wr_err", err, 1);
		rw(0, ADR_IDX_ID, 0);
		chk("id_again", rl, {24'h0, ID_VAL});
		rw(0, 6'h08, 0);
		chk("unmapped_err", err, 1);
	endtask

	task automatic t_axes();
		load(12'h8A5, 12'h7F3, 12'h00C);
		for (int a = 0; a < 3; a++) begin
			// Offsets 2/3, 4/5, 6/7 per axis
			i_adr_host.rd_pair(ADR_IDX_X_LOW + 6'(2 * a), rl, rh);
			chk("low", rl & 32'hF1, {24'h0, smp[a][3:0], 4'h1});
			chk("high", rh, {24'h0, smp[a][11:4]});
			rw(0, ADR_IDX_X_LOW + 6'(2 * a), 0);
			chk("fresh_clr", rl[0], 0);
			// Releases the lock taken by the low read just above
			rw(0, ADR_IDX_X_HIGH + 6'(2 * a), 0);
			chk("relock_high", rl, {24'h0, smp[a][11:4]});
		end
	endtask

	task automatic t_lock();
		load(12'h123, 0, 0);
		rw(0, ADR_IDX_X_LOW, 0);
		load(12'hABC, 0, 0);
		rw(0, ADR_IDX_X_HIGH, 0);
		chk("locked_high", rl, 32'h12);
		rw(0, ADR_IDX_STS, 0);
		chk("sts_ovr", rl[1], 1);
		rw(0, ADR_IDX_X_HIGH, 0);
		chk("released_high", rl, 32'hAB);
		rw(1, ADR_IDX_CTRL, 1);
		rw(0, ADR_IDX_X_LOW, 0);
		load(12'h456, 0, 0);
		rw(0, ADR_IDX_X_HIGH, 0);
		chk("unlocked_high", rl, 32'h45);
		rw(1, ADR_IDX_CTRL, 0);
	endtask

	task automatic t_sleep();
		rw(1, ADR_IDX_CTRL, 2);
		rw(0, ADR_IDX_Y_LOW, 0);
		chk("sleep_err", err, 1);
		chk("sleep_data", rl, 0);
		rw(1, ADR_IDX_CTRL, 0);
		rw(0, ADR_IDX_Y_LOW, 0);
		chk("awake_err", err, 0);
	endtask

	task automatic t_irq();
		rw(1, ADR_IDX_STS, 3);
		rw(1, ADR_IDX_MASK, 0);
		load(12'h001, 12'h002, 12'h003);
		@(negedge clk);
		chk("irq_masked", irq, 0);
		rw(1, ADR_IDX_MASK, 1);
		@(negedge clk);
		chk("irq_set", irq, 1);
		rw(1, ADR_IDX_STS, 1);
		@(negedge clk);
		chk("irq_clr", irq, 0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		s_valid = 1'b0;
		sx = 12'h0;
		sy = 12'h0;
		sz = 12'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_ident();
		t_axes();
		t_lock();
		t_sleep();
		t_irq();
		final_report();
	end

	// Whole run is under two hundred cycles
	initial begin
		#100000;
		num_errors++;
		final_report();
	end
endmodule // tb_adr_regs
